/* File: rtl/twsio_channel.sv */
// one three-wire serial channel: shifter, bit counter, clock and pins
`timescale 1ns/10ps
`include "twsio_map.svh"
module twsio_channel (
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    input  wire logic [7:0] ctl_i,        // this channel's control byte
    input  wire logic       sr_wr_i,      // shift register write strobe
    input  wire logic [7:0] sr_wdata_i,   // shift register write data
    input  wire logic       sr_rd_i,      // shift register read strobe
    input  wire logic       sck_in_i,     // serial clock from the pin
    input  wire logic       sin_i,        // serial in from the pin
    output logic      [7:0] sr_o,         // shift register contents
    output logic            done_o,       // transfer done pulse
    output logic            busy_o,       // transfer in progress
    output logic            sck_o,        // serial clock out
    output logic            sck_oe_o,     // serial clock drive enable
    output logic            sout_o,       // serial data out
    output logic            sout_oe_o,    // serial data drive enable
    output logic            sin_used_o    // serial in claimed by channel
);
    typedef struct packed {
        twsio_pkg::twsio_state_t st;   // master clock phase
        logic [7:0] sr;                // shift register
        logic [3:0] cnt;               // bits moved this transfer
        logic [7:0] div;               // half period counter
        logic       sck_q;             // last sampled external clock
        logic       so;                // output latch
        logic       sck;               // driven clock level
        logic       done;              // transfer done pulse
        logic       busy;              // transfer running
        logic       sck_oe;
        logic       so_oe;
        logic       si_used;
        logic [3:0] falls;             // master clock falls this transfer
    } twsio_ch_t;

    twsio_ch_t cur;
    twsio_ch_t next_cur;

    logic                      en;
    logic                      rx_only;
    twsio_pkg::twsio_clksel_t  csel;
    logic [7:0]                half;
    assign en      = ctl_i[`TWSIO_BIT_ENABLE];
    assign rx_only = ctl_i[`TWSIO_BIT_RX_ONLY];
    assign csel    = twsio_pkg::twsio_clksel_t'(
                     {ctl_i[`TWSIO_BIT_CLK_HI], ctl_i[`TWSIO_BIT_CLK_LO]});

    // half period of the internal clock in main clock cycles
    always_comb begin
        case (csel)
            twsio_pkg::TWSIO_CLK_DIV8:  half = `TWSIO_HALF_DIV8;
            twsio_pkg::TWSIO_CLK_DIV16: half = `TWSIO_HALF_DIV16;
            default:                    half = `TWSIO_HALF_DIV32;
        endcase
    end

    // next state of the whole channel
    always_comb begin
        logic start;
        logic fall;
        logic rise;
        logic ext;
        start = 1'b0;
        fall  = 1'b0;
        rise  = 1'b0;
        ext   = (csel == twsio_pkg::TWSIO_CLK_EXT);
        next_cur = cur;
        next_cur.done  = 1'b0;
        next_cur.sck_q = sck_in_i;
        // trigger: write in send modes, read in receive-only mode
        if (en && !cur.busy) begin
            start = rx_only ? sr_rd_i : sr_wr_i;
        end
        if (sr_wr_i && !cur.busy) begin
            next_cur.sr = sr_wdata_i;
        end
        if (!en) begin
            // stopped: counter held clear, clock released
            next_cur.st   = twsio_pkg::TWSIO_IDLE;
            next_cur.cnt  = 4'h0;
            next_cur.busy = 1'b0;
            next_cur.sck  = 1'b1;
        end else if (start) begin
            next_cur.busy = 1'b1;
            next_cur.cnt  = 4'h0;
            next_cur.div  = 8'h00;
            next_cur.st   = ext ? twsio_pkg::TWSIO_IDLE
                                : twsio_pkg::TWSIO_HIGH;
        end else if (cur.busy) begin
            if (ext) begin
                // slave: edges come from the far party
                fall = cur.sck_q && !sck_in_i;
                rise = !cur.sck_q && sck_in_i;
            end else if (cur.div == half - 8'h01) begin
                next_cur.div = 8'h00;
                case (cur.st)
                    twsio_pkg::TWSIO_HIGH: begin
                        fall = 1'b1;
                        next_cur.sck = 1'b0;
                        next_cur.st  = twsio_pkg::TWSIO_LOW;
                    end
                    twsio_pkg::TWSIO_LOW: begin
                        rise = 1'b1;
                        next_cur.sck = 1'b1;
                        next_cur.st  = twsio_pkg::TWSIO_HIGH;
                    end
                    default: next_cur.st = twsio_pkg::TWSIO_HIGH;
                endcase
            end else begin
                next_cur.div = cur.div + 8'h01;
            end
            // drive on falling edge, msb first
            if (fall) begin
                next_cur.so = rx_only ? 1'b0 : cur.sr[7];
            end
            // sample on rising edge, eight bits then stop itself
            if (rise) begin
                next_cur.sr  = {cur.sr[6:0], sin_i};
                next_cur.cnt = cur.cnt + 4'h1;
                if (cur.cnt == `TWSIO_BITS_PER_XFER - 4'h1) begin
                    next_cur.busy = 1'b0;
                    next_cur.done = 1'b1;
                    next_cur.st   = twsio_pkg::TWSIO_IDLE;
                    next_cur.sck  = 1'b1;
                end
            end
        end
        // pin ownership follows enable and mode
        next_cur.sck_oe  = en && !ext;
        next_cur.so_oe   = en && !rx_only;
        // serial in is only sampled, never driven, but stays claimed whenever the channel is enabled
        next_cur.si_used = en;
        if (!en || rx_only) begin
            next_cur.so = 1'b0;
        end
        // master falling edges, restarted with every transfer
        if (next_cur.busy && !cur.busy) begin
            next_cur.falls = 4'h0;
        end else if (cur.sck_oe && cur.sck && !next_cur.sck) begin
            next_cur.falls = cur.falls + 4'h1;
        end
    end

    // register the channel state
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur <= '{st: twsio_pkg::TWSIO_IDLE, sr: 8'h00, cnt: 4'h0,
                     div: 8'h00, sck_q: 1'b1, so: 1'b0, sck: 1'b1,
                     done: 1'b0, busy: 1'b0, sck_oe: 1'b0, so_oe: 1'b0,
                     si_used: 1'b0, falls: 4'h0};
        end else begin
            cur <= next_cur;
        end
    end

    assign sr_o       = cur.sr;
    assign done_o     = cur.done;
    assign busy_o     = cur.busy;
    assign sck_o      = cur.sck;
    assign sck_oe_o   = cur.sck_oe;
    assign sout_o     = cur.so;
    assign sout_oe_o  = cur.so_oe;
    assign sin_used_o = cur.si_used;

    property p_disabled_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !en |=> (cur.cnt == 4'h0) && !busy_o;
    endproperty
    a_disabled_clear: assert property (p_disabled_clear)
        else $error("counter not cleared while disabled");

    property p_rx_low;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (en && rx_only) ##1 (en && rx_only) |=> !sout_o && !sout_oe_o;
    endproperty
    a_rx_low: assert property (p_rx_low)
        else $error("serial out not low in receive-only mode");

    property p_idle_high;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (sck_oe_o && !busy_o) |-> sck_o;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("master clock not high when idle");

    property p_eight;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (sck_oe_o && done_o) |-> (cur.falls == `TWSIO_BITS_PER_XFER);
    endproperty
    a_eight: assert property (p_eight)
        else $error("master transfer without eight clock pulses");

    // a transfer starts only on a strobe of that very cycle, so a write
    // made while disabled can never launch later
    property p_no_start_off;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (!busy_o && !sr_wr_i && !sr_rd_i) |=> !busy_o;
    endproperty
    a_no_start_off: assert property (p_no_start_off)
        else $error("transfer started while disabled");

    property p_div8_len;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (en && csel == twsio_pkg::TWSIO_CLK_DIV8 && sr_wr_i && !rx_only
         && !busy_o) ##1 (en && csel == twsio_pkg::TWSIO_CLK_DIV8) [*8]
        |-> ##[50:70] done_o;
    endproperty
    a_div8_len: assert property (p_div8_len)
        else $error("divide by eight transfer too long");

    c_tx: cover property (@(posedge mclk_i) busy_o ##1 done_o);
    c_rx: cover property (@(posedge mclk_i) rx_only && done_o);
    c_ext: cover property (@(posedge mclk_i) !sck_oe_o && done_o);
endmodule : twsio_channel

/* File: rtl/twsio_map.svh */
// register offsets, field positions, reset values and divider half periods
`ifndef TWSIO_MAP_SVH
`define TWSIO_MAP_SVH
`define TWSIO_CTL_CH0_ADDR  16'hffb0
`define TWSIO_CTL_CH1_ADDR  16'hffb8
`define TWSIO_CTL_RESET     8'h00
`define TWSIO_BIT_ENABLE    7
`define TWSIO_BIT_RX_ONLY   2
`define TWSIO_BIT_CLK_HI    1
`define TWSIO_BIT_CLK_LO    0
`define TWSIO_CTL_RW_MASK   8'h87
`define TWSIO_HALF_DIV8     8'h04
`define TWSIO_HALF_DIV16    8'h08
`define TWSIO_HALF_DIV32    8'h10
`define TWSIO_BITS_PER_XFER 4'h8
`endif

/* File: rtl/twsio_pkg.sv */
// types shared by the three-wire serial channel logic
package twsio_pkg;
    typedef enum logic [2:0] {
        TWSIO_IDLE  = 3'b001,
        TWSIO_LOW   = 3'b010,
        TWSIO_HIGH  = 3'b100
    } twsio_state_t;
    typedef enum logic [1:0] {
        TWSIO_CLK_EXT   = 2'h0,
        TWSIO_CLK_DIV8  = 2'h1,
        TWSIO_CLK_DIV16 = 2'h2,
        TWSIO_CLK_DIV32 = 2'h3
    } twsio_clksel_t;
endpackage : twsio_pkg

/* File: rtl/twsio_top.sv */
// two-channel three-wire serial port with its control registers
`timescale 1ns/10ps
`include "twsio_map.svh"
module twsio_top #(
    parameter int CHANNELS = 2
) (
    input  wire logic                 mclk_i,
    input  wire logic                 reset_n_i,
    input  wire logic [15:0]          addr_i,      // cpu address
    input  wire logic                 wr_i,        // cpu byte write
    input  wire logic                 bit_wr_i,    // cpu single-bit write
    input  wire logic [2:0]           bit_sel_i,   // bit for bit_wr_i
    input  wire logic [7:0]           wdata_i,     // cpu write data
    input  wire logic [CHANNELS-1:0]  sr_wr_i,     // shift reg writes
    input  wire logic [CHANNELS-1:0]  sr_rd_i,     // shift reg reads
    input  wire logic [CHANNELS-1:0]  sck_in_i,
    input  wire logic [CHANNELS-1:0]  sin_i,
    output logic      [7:0]           rdata_o,     // control reg read
    output logic [CHANNELS*8-1:0]     sr_o,
    output logic [CHANNELS-1:0]       done_o,      // xfer_done_flag set
    output logic [CHANNELS-1:0]       busy_o,
    output logic [CHANNELS-1:0]       sck_o,
    output logic [CHANNELS-1:0]       sck_oe_o,
    output logic [CHANNELS-1:0]       sout_o,
    output logic [CHANNELS-1:0]       sout_oe_o,
    output logic [CHANNELS-1:0]       sin_used_o
);
    typedef struct packed {
        logic [CHANNELS-1:0][7:0] ctl;   // mode_control_reg per channel
        logic [7:0]               rd;    // registered read data
    } twsio_top_t;

    twsio_top_t cur;
    twsio_top_t next_cur;

    // address of a channel's control register
    function automatic logic [15:0] ctl_addr(input int ch);
        ctl_addr = (ch == 0) ? `TWSIO_CTL_CH0_ADDR : `TWSIO_CTL_CH1_ADDR;
    endfunction : ctl_addr

    ////////////////////////////////////////////////////////////////////
    // register writes and readback
    always_comb begin
        next_cur = cur;
        next_cur.rd = 8'h00;
        for (int c = 0; c < CHANNELS; c++) begin
            if (addr_i == ctl_addr(c)) begin
                if (wr_i) begin
                    next_cur.ctl[c] = wdata_i & `TWSIO_CTL_RW_MASK;
                end else if (bit_wr_i) begin
                    next_cur.ctl[c][bit_sel_i] = wdata_i[0];
                    next_cur.ctl[c] = next_cur.ctl[c] & `TWSIO_CTL_RW_MASK;
                end
                next_cur.rd = cur.ctl[c];
            end
        end
    end

    // clear on reset to disabled, send mode, external clock
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur <= '{ctl: {CHANNELS{`TWSIO_CTL_RESET}}, rd: 8'h00};
        end else begin
            cur <= next_cur;
        end
    end
    assign rdata_o = cur.rd;

    ////////////////////////////////////////////////////////////////////
    // identical channels, each with its own control byte
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        twsio_channel u_ch (
            .mclk_i     (mclk_i),
            .reset_n_i  (reset_n_i),
            .ctl_i      (cur.ctl[g]),
            .sr_wr_i    (sr_wr_i[g]),
            .sr_wdata_i (wdata_i),
            .sr_rd_i    (sr_rd_i[g]),
            .sck_in_i   (sck_in_i[g]),
            .sin_i      (sin_i[g]),
            .sr_o       (sr_o[g*8 +: 8]),
            .done_o     (done_o[g]),
            .busy_o     (busy_o[g]),
            .sck_o      (sck_o[g]),
            .sck_oe_o   (sck_oe_o[g]),
            .sout_o     (sout_o[g]),
            .sout_oe_o  (sout_oe_o[g]),
            .sin_used_o (sin_used_o[g])
        );
    end

    property p_reserved_zero;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (wr_i && addr_i == `TWSIO_CTL_CH0_ADDR) |=> ##1
        (rdata_o[6:3] == 4'h0) || (addr_i != `TWSIO_CTL_CH0_ADDR);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits not zero");

    ////////////////////////////////////////////////////////////////////
    // per-channel checks, so the second channel is held to the same rules
    for (genvar k = 0; k < CHANNELS; k++) begin : g_chk
        property p_write_lands;
            @(posedge mclk_i) disable iff (!reset_n_i)
            (wr_i && addr_i == ctl_addr(k)) |=>
            (cur.ctl[k] == ($past(wdata_i) & `TWSIO_CTL_RW_MASK));
        endproperty
        a_write_lands: assert property (p_write_lands)
            else $error("control write lost");

        property p_ext_slave;
            @(posedge mclk_i) disable iff (!reset_n_i)
            (cur.ctl[k][1:0] == 2'h0) |=> !sck_oe_o[k];
        endproperty
        a_ext_slave: assert property (p_ext_slave)
            else $error("clock driven with external clock selected");

        property p_off_release;
            @(posedge mclk_i) disable iff (!reset_n_i)
            !cur.ctl[k][7] |=> !sck_oe_o[k] && !sout_oe_o[k]
                               && !sin_used_o[k];
        endproperty
        a_off_release: assert property (p_off_release)
            else $error("disabled channel holds pins");
    end

    c_bitwr: cover property (@(posedge mclk_i) bit_wr_i ##1 rdata_o[7]);
endmodule : twsio_top

/* File: verif/twsio_peer.sv */
// far-side clocked serial peripheral model for one channel
`timescale 1ns/10ps
module twsio_peer (
    input  wire logic       mclk_i,
    input  wire logic       sck_o_i,    // device clock level
    input  wire logic       sck_oe_i,   // device clock drive enable
    input  wire logic       sout_i,     // device data out
    input  wire logic       sout_oe_i,  // device data drive enable
    input  wire logic [7:0] tx_i,       // byte this side sends
    output logic            sck_line_o, // resolved clock line
    output logic            sin_o,      // data toward the device
    output logic      [7:0] rx_o        // byte this side captured
);
    logic ext_sck = 1'b1;  // own clock, stands high between frames
    logic prev    = 1'b1;  // line level one main cycle ago
    int   idx     = 7;     // next bit to send, msb first
    initial sin_o = 1'b0;
    initial rx_o  = 8'h00;
    // this side's own clock sits on the line whenever the device does not drive it
    assign sck_line_o = sck_oe_i ? sck_o_i : ext_sck;
    ////////////////////////////////////////////////////////////////////
    // change data on falling, sample on rising, as the device does
    always @(posedge mclk_i) begin
        prev <= sck_line_o;
        if (prev && !sck_line_o) begin
            sin_o <= tx_i[idx];
        end
        if (!prev && sck_line_o) begin
            rx_o <= {rx_o[6:0], sout_oe_i ? sout_i : 1'b1};
            idx  <= (idx == 0) ? 7 : idx - 1;
            // released after the last bit: show the inverse, not a hold
            if (idx == 0) begin
                sin_o <= ~sin_o;
            end
        end
    end
    // clock made by this side when the device selects external clock
    task automatic run_clock(input int half);
        repeat (8) begin
            repeat (half) @(negedge mclk_i);
            ext_sck = 1'b0;
            repeat (half) @(negedge mclk_i);
            ext_sck = 1'b1;
        end
    endtask : run_clock
endmodule : twsio_peer

/* File: verif/tb.sv */
// self-checking bench for the two-channel three-wire serial port
`timescale 1ns/10ps
module tb;
    logic        mclk_i;
    logic        reset_n_i;
    logic [15:0] addr_i;
    logic        wr_i, bit_wr_i;
    logic [2:0]  bit_sel_i;
    logic [7:0]  wdata_i, rdata_o;
    logic [1:0]  sr_wr_i, sr_rd_i, done_o, busy_o, sck_o, sck_oe_o;
    logic [1:0]  sout_o, sout_oe_o, sin_used_o, sck_line, sin_w;
    logic [15:0] sr_o;
    logic [7:0]  rx_w [2];
    int          fail_count = 0;
    int          comparisons = 0;
    always #5 mclk_i = ~mclk_i;
    twsio_top #(.CHANNELS(2)) u_dut (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_i(wr_i),
        .bit_wr_i(bit_wr_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i),
        .sr_wr_i(sr_wr_i), .sr_rd_i(sr_rd_i), .sck_in_i(sck_line),
        .sin_i(sin_w), .rdata_o(rdata_o), .sr_o(sr_o), .done_o(done_o),
        .busy_o(busy_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
        .sout_o(sout_o), .sout_oe_o(sout_oe_o), .sin_used_o(sin_used_o));
    for (genvar i = 0; i < 2; i++) begin : g_peer
        twsio_peer u_peer (.mclk_i(mclk_i), .sck_o_i(sck_o[i]),
            .sck_oe_i(sck_oe_o[i]), .sout_i(sout_o[i]),
            .sout_oe_i(sout_oe_o[i]), .tx_i(i ? 8'hc3 : 8'h3c),
            .sck_line_o(sck_line[i]), .sin_o(sin_w[i]), .rx_o(rx_w[i]));
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // strobes drop and a cycle passes, so calls may follow back to back
    task automatic wr_ctl(input logic [15:0] a, input logic [7:0] d);
        addr_i = a; wdata_i = d; wr_i = 1'b1;
        @(negedge mclk_i); wr_i = 1'b0;
        @(negedge mclk_i);
    endtask : wr_ctl
    task automatic wr_bit(input logic [15:0] a, input logic [2:0] s,
                          input logic v);
        addr_i = a; bit_sel_i = s; wdata_i = {7'h00, v}; bit_wr_i = 1'b1;
        @(negedge mclk_i); bit_wr_i = 1'b0;
        @(negedge mclk_i);
    endtask : wr_bit
    task automatic rd_ctl(input logic [15:0] a, output logic [7:0] d);
        addr_i = a;
        @(negedge mclk_i); d = rdata_o;
    endtask : rd_ctl
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] d;
        rd_ctl(16'hffb0, d); check(d, 8'h00);
        rd_ctl(16'hffb8, d); check(d, 8'h00);
        check({sck_oe_o, sout_oe_o, sin_used_o}, 8'h00);
        wr_ctl(16'hffb0, 8'hff);
        rd_ctl(16'hffb0, d); check(d, 8'h87);
        wr_bit(16'hffb8, 3'h2, 1'b1);
        rd_ctl(16'hffb8, d); check(d, 8'h04);
        wr_bit(16'hffb0, 3'h7, 1'b0);
        rd_ctl(16'hffb0, d); check(d, 8'h07);
        rd_ctl(16'hffb4, d); check(d, 8'h00); // unmapped reads zero
        $display("test regs done");
    endtask : t_regs
    // data loaded while off must not launch once the channel turns on
    task automatic t_early_load;
        wdata_i = 8'ha5; sr_wr_i[0] = 1'b1;
        @(negedge mclk_i); sr_wr_i[0] = 1'b0;
        wr_ctl(16'hffb0, 8'h81);
        repeat (20) @(negedge mclk_i);
        check({busy_o[0], sck_line[0]}, 8'h01);
        $display("test early load done");
    endtask : t_early_load
    // one whole byte; code 0 of ctl[1:0] has channel 0's peer make the clock
    task automatic xfer(input int ch, input logic [7:0] ctl,
                        input logic [7:0] data);
        int   lows, falls, dones, n;
        logic prev, rxo;
        lows = 0; falls = 0; dones = 0; n = 0; prev = 1'b1; rxo = ctl[2];
        wr_ctl(ch ? 16'hffb8 : 16'hffb0, ctl);
        wdata_i = data;
        if (rxo) sr_rd_i[ch] = 1'b1; else sr_wr_i[ch] = 1'b1;
        @(negedge mclk_i); sr_rd_i = 2'h0; sr_wr_i = 2'h0;
        check(busy_o[ch], 1'b1);
        fork
            if (ctl[1:0] == 2'h0) g_peer[0].u_peer.run_clock(6);
        join_none
        while (dones == 0 && n < 3000) begin
            @(negedge mclk_i);
            n++;
            if (prev && !sck_line[ch]) falls++;
            prev = sck_line[ch];
            if (sck_oe_o[ch] && !sck_o[ch]) lows++;
            if (done_o[ch]) dones++;
            if (rxo) check({sout_oe_o[ch], sout_o[ch]}, 8'h00);
            if (ctl[1:0] == 2'h0) check(sck_oe_o[ch], 1'b0);
        end
        check(8'(dones), 8'h01);
        check(8'(falls), 8'h08);
        if (ctl[1:0] != 2'h0) check(8'(lows), 8'(16 << ctl[1:0]));
        @(negedge mclk_i);
        check({busy_o[ch], sck_line[ch]}, 8'h01);
        check(sr_o[ch*8 +: 8], ch ? 8'hc3 : 8'h3c);
        if (!rxo) check(rx_w[ch], data);
        $display("test transfer ch%0d ctl %h done", ch, ctl);
    endtask : xfer
    // turning the channel off mid-byte stops it and frees the pins
    task automatic t_abort;
        wr_ctl(16'hffb0, 8'h83);
        wdata_i = 8'h5a; sr_wr_i[0] = 1'b1;
        @(negedge mclk_i); sr_wr_i[0] = 1'b0;
        repeat (40) @(negedge mclk_i);
        wr_ctl(16'hffb0, 8'h03);
        check({busy_o[0], sck_oe_o[0], sout_oe_o[0], sin_used_o[0]},
              8'h00);
        $display("test abort done");
    endtask : t_abort
    ////////////////////////////////////////////////////////////////////
    // watchdog: the whole run needs a few thousand cycles at most
    initial begin
        repeat (40000) @(posedge mclk_i);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        mclk_i = 1'b0; reset_n_i = 1'b0; addr_i = 16'h0000; wr_i = 1'b0;
        bit_wr_i = 1'b0; bit_sel_i = 3'h0; wdata_i = 8'h00;
        sr_wr_i = 2'h0; sr_rd_i = 2'h0;
        repeat (10) @(negedge mclk_i);
        reset_n_i = 1'b1;
        @(negedge mclk_i);
        t_regs();
        t_early_load();
        xfer(0, 8'h81, 8'ha5);
        xfer(0, 8'h82, 8'h01);
        xfer(0, 8'h83, 8'h80);
        xfer(1, 8'h85, 8'h00);
        xfer(0, 8'h80, 8'h96);
        t_abort();
        tally_and_finish();
    end
endmodule : tb
